// >>> core/event_flag_status_bank.sv
// Sticky event flag bank with its 16-bit serial read and clear port.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// RULE1 - Flags stay set after an event; writing one clears, writing zero keeps.
// RULE2 - Missed watchdog trigger sets warning bit 3; other bits read zero.
// RULE3 - Output-control command area access error sets serial bit 6; bit 7 zero.
// RULE4 - Device-control command area access error sets serial bit 5.
// RULE5 - Lock or unlock access error sets serial bit 4.
// RULE6 - Chip select low beyond 2 ms sets serial bit 3.
// RULE7 - Frame to an address outside the bank sets serial bit 2.
// RULE8 - Frame with a clock count other than 16 sets serial bit 1.
// RULE9 - Frame failing its parity check sets serial bit 0.
// RULE10 - Second external rail short sets short bit 7.
// RULE11 - First external rail short sets short bit 6; bits 5, 3:2 zero.
// RULE12 - Step-up regulator short sets short bit 4.
// RULE13 - Second step-down regulator short sets short bit 1.
// RULE14 - First step-down regulator short sets short bit 0.
// RULE15 - Second external rail overvoltage sets overvoltage bit 7.
// RULE16 - First external rail overvoltage sets bit 6; bits 5, 3:2 zero.
// RULE17 - Step-up, second and first step-down overvoltage set bits 4, 1, 0.
// RULE18 - An event coinciding with its clear leaves the flag set.
module event_flag_status_bank #(
   parameter int SELECT_LIMIT_CYCLES = flag_bank_pkg::SELECT_LIMIT_CYC
) (
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic       clk_en,
   input  wire logic       sclk,
   input  wire logic       cs_n,
   input  wire logic       mosi,
   output logic            miso,
   output logic            miso_oe,
   input  wire logic       watchdog_missed_trigger,
   input  wire logic       output_ctrl_access_error,
   input  wire logic       device_ctrl_access_error,
   input  wire logic       lock_access_error,
   input  wire logic       ext_rail_two_short,
   input  wire logic       ext_rail_one_short,
   input  wire logic       stepup_short,
   input  wire logic       stepdown_two_short,
   input  wire logic       stepdown_one_short,
   input  wire logic       ext_rail_two_overvoltage,
   input  wire logic       ext_rail_one_overvoltage,
   input  wire logic       stepup_overvoltage,
   input  wire logic       stepdown_two_overvoltage,
   input  wire logic       stepdown_one_overvoltage,
   output logic      [flag_bank_pkg::DATA_W-1:0] mcu_warning_flags,
   output logic      [flag_bank_pkg::DATA_W-1:0] serial_error_flags,
   output logic      [flag_bank_pkg::DATA_W-1:0] rail_short_flags,
   output logic      [flag_bank_pkg::DATA_W-1:0] rail_overvoltage_flags
);
   import flag_bank_pkg::*;

   typedef struct packed {
      logic              sclk_s1;
      logic              sclk_s2;
      logic              sclk_d;
      logic              cs_s1;
      logic              cs_s2;
      logic              mosi_s1;
      logic              mosi_s2;
      frame_st_e         st;
      logic [15:0]       rx;
      logic [15:0]       tx;
      logic [BITCNT_W-1:0] bits;
      logic [SEL_TIME_W-1:0] sel_time;
      logic              sel_over;
      logic [7:0]        spi_err;
      logic              clr_wr;
      logic [1:0]        clr_idx;
      logic [7:0]        clr_data;
      logic              miso;
      logic              miso_oe;
   } spi_state_s;

   localparam logic [SEL_TIME_W-1:0] SEL_TIME_LAST = SEL_TIME_W'(SELECT_LIMIT_CYCLES - 1);

   spi_state_s  s_reg;
   spi_state_s  s_next;
   logic [7:0]  flag_val [NUM_REGS];
   logic [7:0]  evt_vec  [NUM_REGS];
   logic [5:0]  rx_addr;
   logic        length_bad;
   logic        parity_bad;
   logic        frame_ok;

   ////////////////////////////////////////////////////////////////////////////////
   // Address decode helpers.

   // True when the address falls on one of the four flag registers.
   function automatic logic in_bank(input logic [ADDR_W-1:0] addr);
      in_bank = (addr >= OFS_MCU_WARNING) && (addr <= OFS_RAIL_OVERVOLT);
   endfunction

   // Index of a flag register inside the bank.
   function automatic logic [1:0] bank_index(input logic [ADDR_W-1:0] addr);
      logic [ADDR_W-1:0] diff;
      diff       = addr - OFS_MCU_WARNING;
      bank_index = diff[1:0];
   endfunction

   // Answer frame: address echo, register data and odd parity.
   function automatic logic [15:0] make_resp(input logic [ADDR_W-1:0] addr,
                                             input logic [DATA_W-1:0] data);
      logic [14:0] body;
      body      = {1'b0, addr, data};
      make_resp = {body, ~(^body)};
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Frame checks seen at the end of a frame.
   assign rx_addr  = s_reg.rx[FR_ADDR_MSB:FR_ADDR_LSB];
   // RULE8 clock count check
   assign length_bad = s_reg.bits != BITS_FULL;
   // RULE9 odd parity check
   assign parity_bad = ~(^s_reg.rx);
   assign frame_ok   = (s_reg.st == FR_END) && !s_reg.sel_over && !length_bad && !parity_bad
                       && in_bank(rx_addr);

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and frame sequencer.
   always_comb begin
      s_next         = s_reg;
      s_next.sclk_s1 = sclk;
      s_next.sclk_s2 = s_reg.sclk_s1;
      s_next.sclk_d  = s_reg.sclk_s2;
      s_next.cs_s1   = cs_n;
      s_next.cs_s2   = s_reg.cs_s1;
      s_next.mosi_s1 = mosi;
      s_next.mosi_s2 = s_reg.mosi_s1;
      s_next.spi_err = 8'h00;
      s_next.clr_wr  = 1'b0;
      case (s_reg.st)
         FR_IDLE: begin
            // Select seen low: start a frame and drive the prepared answer.
            if (!s_reg.cs_s2) begin
               s_next.st      = FR_SHIFT;
               s_next.bits    = '0;
               s_next.sel_time = '0;
               s_next.sel_over = 1'b0;
               s_next.miso_oe = 1'b1;
               s_next.miso    = s_reg.tx[15];
            end
         end
         FR_SHIFT: begin
            if (s_reg.cs_s2) begin
               s_next.st      = FR_END;
               s_next.miso_oe = 1'b0;
               s_next.miso    = 1'b0;
            end else begin
               // Sample on the rising clock edge, counting up to saturation.
               if (s_reg.sclk_s2 && !s_reg.sclk_d) begin
                  s_next.rx = {s_reg.rx[14:0], s_reg.mosi_s2};
                  if (s_reg.bits != BITS_SAT) begin
                     s_next.bits = s_reg.bits + 1'b1;
                  end
               end
               // Shift the answer out on the falling clock edge.
               if (!s_reg.sclk_s2 && s_reg.sclk_d) begin
                  s_next.tx   = {s_reg.tx[14:0], 1'b0};
                  s_next.miso = s_reg.tx[14];
               end
               // RULE6 select duration watch
               if (!s_reg.sel_over) begin
                  if (s_reg.sel_time == SEL_TIME_LAST) begin
                     s_next.sel_over             = 1'b1;
                     s_next.spi_err[SE_DURATION] = 1'b1;
                  end else begin
                     s_next.sel_time = s_reg.sel_time + 1'b1;
                  end
               end
            end
         end
         FR_END: begin
            s_next.st = FR_IDLE;
            // A frame that overran the select limit is dropped without action.
            if (s_reg.sel_over) begin
               s_next.tx = 16'h0000;
            end else if (length_bad) begin
               // RULE8 flag bad length
               s_next.spi_err[SE_LENGTH] = 1'b1;
               s_next.tx                 = 16'h0000;
            end else if (parity_bad) begin
               // RULE9 flag bad parity
               s_next.spi_err[SE_PARITY] = 1'b1;
               s_next.tx                 = 16'h0000;
            end else if (!in_bank(rx_addr)) begin
               // RULE7 flag bad address
               s_next.spi_err[SE_ADDRESS] = 1'b1;
               s_next.tx                  = 16'h0000;
            end else begin
               // Answer holds the flags as they stood before any clear.
               s_next.tx = make_resp(rx_addr, flag_val[bank_index(rx_addr)]);
               // RULE1 write frame clears
               if (s_reg.rx[FR_WRITE_BIT]) begin
                  s_next.clr_wr   = 1'b1;
                  s_next.clr_idx  = bank_index(rx_addr);
                  s_next.clr_data = s_reg.rx[FR_DATA_MSB:FR_DATA_LSB];
               end
            end
         end
         default: begin
            s_next.st = FR_IDLE;
         end
      endcase
   end

   // State register; the select synchroniser resets to the idle high level.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_reg       <= '0;
         s_reg.cs_s1 <= 1'b1;
         s_reg.cs_s2 <= 1'b1;
      end else if (clk_en) begin
         s_reg <= s_next;
      end
   end

   assign miso    = s_reg.miso;
   assign miso_oe = s_reg.miso_oe;

   ////////////////////////////////////////////////////////////////////////////////
   // Event routing into the flag registers.
   always_comb begin
      evt_vec[0] = 8'h00;
      evt_vec[1] = s_reg.spi_err;
      evt_vec[2] = 8'h00;
      evt_vec[3] = 8'h00;
      // RULE2 watchdog miss bit
      evt_vec[0][MW_WD_MISS]  = watchdog_missed_trigger;
      // RULE3 output control error
      evt_vec[1][SE_OUTCTRL]  = output_ctrl_access_error;
      // RULE4 device control error
      evt_vec[1][SE_DEVICE_CTRL_ACCESS_ERROR]  = device_ctrl_access_error;
      // RULE5 lock access error
      evt_vec[1][SE_LOCK]     = lock_access_error;
      // RULE10 second rail short
      evt_vec[2][RB_EXT_TWO]  = ext_rail_two_short;
      // RULE11 first rail short
      evt_vec[2][RB_EXT_ONE]  = ext_rail_one_short;
      // RULE12 step-up short
      evt_vec[2][RB_STEPUP]   = stepup_short;
      // RULE13 second step-down short
      evt_vec[2][RB_SD_TWO]   = stepdown_two_short;
      // RULE14 first step-down short
      evt_vec[2][RB_SD_ONE]   = stepdown_one_short;
      // RULE15 second rail overvoltage
      evt_vec[3][RB_EXT_TWO]  = ext_rail_two_overvoltage;
      // RULE16 first rail overvoltage
      evt_vec[3][RB_EXT_ONE]  = ext_rail_one_overvoltage;
      // RULE17 regulator overvoltage bits
      evt_vec[3][RB_STEPUP]   = stepup_overvoltage;
      evt_vec[3][RB_SD_TWO]   = stepdown_two_overvoltage;
      evt_vec[3][RB_SD_ONE]   = stepdown_one_overvoltage;
   end

   // One sticky register per bank slot; unused bits are masked to zero.
   for (genvar g = 0; g < NUM_REGS; g++) begin : g_bank
      event_flag_reg #(
         .USED_MASK (USED_MASK[g])
      ) u_flags (
         .clk      (clk),
         .arst_n   (arst_n),
         .clk_en   (clk_en),
         .event_in (evt_vec[g]),
         .clr_wr   (s_reg.clr_wr && (s_reg.clr_idx == 2'(g))),
         .clr_data (s_reg.clr_data),
         .flags    (flag_val[g])
      );
   end

   assign mcu_warning_flags      = flag_val[0];
   assign serial_error_flags     = flag_val[1];
   assign rail_short_flags       = flag_val[2];
   assign rail_overvoltage_flags = flag_val[3];

   ////////////////////////////////////////////////////////////////////////////////
   // Checks tying causes to flags, plus unused short bits and data-out release.
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   AST_LENGTH_ERR: assert property ((clk_en && s_reg.st == FR_END && !s_reg.sel_over
                                    && length_bad) ##1 clk_en
                                   |=> serial_error_flags[SE_LENGTH]) // RULE8
      else $error("length error not flagged");
   AST_PARITY_ERR: assert property ((clk_en && s_reg.st == FR_END && !s_reg.sel_over
                                    && !length_bad && parity_bad) ##1 clk_en
                                   |=> serial_error_flags[SE_PARITY]) // RULE9
      else $error("parity error not flagged");
   AST_ADDR_ERR: assert property ((clk_en && s_reg.st == FR_END && !s_reg.sel_over && !length_bad
                                   && !parity_bad && !in_bank(rx_addr)) ##1 clk_en
                                  |=> serial_error_flags[SE_ADDRESS]) // RULE7
      else $error("address error not flagged");
   AST_SELECT_ERR: assert property ((clk_en && s_reg.st == FR_SHIFT && !s_reg.cs_s2
                                    && !s_reg.sel_over && s_reg.sel_time == SEL_TIME_LAST)
                                   ##1 clk_en |=> serial_error_flags[SE_DURATION]) // RULE6
      else $error("select duration error not flagged");
   AST_WD_MISS: assert property (clk_en && watchdog_missed_trigger
                                 |=> mcu_warning_flags[MW_WD_MISS]) // RULE2
      else $error("watchdog miss not flagged");
   AST_OUTCTRL: assert property (clk_en && output_ctrl_access_error
                                 |=> serial_error_flags[SE_OUTCTRL]) // RULE3
      else $error("output control error not flagged");
   AST_EXT_TWO_SHORT: assert property (clk_en && ext_rail_two_short
                                       |=> rail_short_flags[RB_EXT_TWO]) // RULE10
      else $error("second rail short not flagged");
   AST_STEPUP_OV: assert property (clk_en && stepup_overvoltage
                                   |=> rail_overvoltage_flags[RB_STEPUP]) // RULE17
      else $error("step-up overvoltage not flagged");
   AST_SHORT_UNUSED: assert property ((rail_short_flags & ~USED_MASK[2]) == 8'h00) // RULE11
      else $error("unused short bit set");
   AST_MISO_RELEASE: assert property (s_reg.st == FR_IDLE && s_reg.cs_s2 |-> !miso_oe)
      else $error("data out driven while deselected");

   COV_READ_OK: cover property (frame_ok && !s_reg.rx[FR_WRITE_BIT]);
   COV_WRITE_OK: cover property (frame_ok && s_reg.rx[FR_WRITE_BIT]);
   COV_LENGTH_ERR: cover property (s_reg.spi_err[SE_LENGTH]);
   COV_SELECT_ERR: cover property (s_reg.spi_err[SE_DURATION]);

endmodule

// >>> core/flag_bank_pkg.sv
// Constants, field layout and frame encoding shared by the event flag bank.
package flag_bank_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Clock and timing.
   localparam int CLK_MHZ          = 100;
   localparam int SELECT_LIMIT_US  = 2000;
   localparam int SELECT_LIMIT_CYC = SELECT_LIMIT_US * CLK_MHZ;
   localparam int SEL_TIME_W       = 18;

   ////////////////////////////////////////////////////////////////////////////////
   // Serial frame layout: write flag, address, data, odd parity over all bits.
   localparam int FRAME_BITS   = 16;
   localparam int BITCNT_W     = 5;
   localparam int FR_WRITE_BIT = 15;
   localparam int FR_ADDR_MSB  = 14;
   localparam int FR_ADDR_LSB  = 9;
   localparam int FR_DATA_MSB  = 8;
   localparam int FR_DATA_LSB  = 1;
   localparam int ADDR_W       = 6;
   localparam int DATA_W       = 8;
   localparam logic [BITCNT_W-1:0] BITS_FULL = 5'h10;
   localparam logic [BITCNT_W-1:0] BITS_SAT  = 5'h11;

   ////////////////////////////////////////////////////////////////////////////////
   // Register offsets, reset value and implemented-bit masks.
   localparam int NUM_REGS = 4;
   localparam logic [ADDR_W-1:0] OFS_MCU_WARNING    = 6'h1E;
   localparam logic [ADDR_W-1:0] OFS_SERIAL_ERROR   = 6'h1F;
   localparam logic [ADDR_W-1:0] OFS_RAIL_SHORT     = 6'h20;
   localparam logic [ADDR_W-1:0] OFS_RAIL_OVERVOLT  = 6'h21;
   localparam logic [DATA_W-1:0] FLAG_RESET         = 8'h00;
   localparam logic [DATA_W-1:0] USED_MASK [NUM_REGS] = '{8'h08, 8'h7F, 8'hD3, 8'hD3};

   ////////////////////////////////////////////////////////////////////////////////
   // Bit positions inside the flag registers.
   localparam int MW_WD_MISS   = 3;
   localparam int SE_OUTCTRL   = 6;
   localparam int SE_DEVICE_CTRL_ACCESS_ERROR   = 5;
   localparam int SE_LOCK      = 4;
   localparam int SE_DURATION  = 3;
   localparam int SE_ADDRESS   = 2;
   localparam int SE_LENGTH    = 1;
   localparam int SE_PARITY    = 0;
   localparam int RB_EXT_TWO   = 7;
   localparam int RB_EXT_ONE   = 6;
   localparam int RB_STEPUP    = 4;
   localparam int RB_SD_TWO    = 1;
   localparam int RB_SD_ONE    = 0;

   ////////////////////////////////////////////////////////////////////////////////
   // Frame sequencer states, Gray coded along idle, shift, end.
   typedef enum logic [1:0] {
      FR_IDLE  = 2'h0,
      FR_SHIFT = 2'h1,
      FR_END   = 2'h3
   } frame_st_e;

endpackage

// >>> core/event_flag_reg.sv
// One 8-bit sticky event flag register with write-one-to-clear.
`timescale 1ns/1ns
module event_flag_reg #(
   parameter logic [7:0] USED_MASK = 8'hFF
) (
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic       clk_en,
   input  wire logic [7:0] event_in,
   input  wire logic       clr_wr,
   input  wire logic [7:0] clr_data,
   output logic      [7:0] flags
);
   import flag_bank_pkg::*;

   typedef struct packed {
      logic [7:0] flags;
   } flag_state_s;

   flag_state_s s_reg;
   flag_state_s s_next;
   logic [7:0]  evt_used;

   ////////////////////////////////////////////////////////////////////////////////
   // Next-state logic: clear on written ones, then let any event on a used bit set its bit.
   always_comb begin
      evt_used = event_in & USED_MASK;
      s_next   = s_reg;
      // RULE1 write one clears
      if (clr_wr) begin
         s_next.flags = s_reg.flags & ~clr_data;
      end
      // RULE18 set beats clear
      s_next.flags = (s_next.flags | evt_used) & USED_MASK;
   end

   // State register, frozen while the clock enable is low.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_reg <= '0;
      end else if (clk_en) begin
         s_reg <= s_next;
      end
   end

   assign flags = s_reg.flags;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks on the flag behaviour.
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   AST_STICKY: assert property (clk_en && !clr_wr |=> (flags & $past(flags)) == $past(flags)) // RULE1
      else $error("flag dropped without a clear");
   AST_W1_CLEARS: assert property (clk_en && clr_wr && evt_used == 8'h00
                                   |=> (flags & $past(clr_data)) == 8'h00) // RULE1
      else $error("written one did not clear its flag");
   AST_SET_WINS: assert property (clk_en && evt_used != 8'h00
                                  |=> (flags & $past(evt_used)) == $past(evt_used)) // RULE18
      else $error("event lost");
   AST_UNUSED_ZERO: assert property ((flags & ~USED_MASK) == 8'h00) // RULE2
      else $error("unused bit reads as one");
   AST_FROZEN: assert property (!clk_en |=> $stable(flags))
      else $error("flags moved while clock enable low");

endmodule

// >>> tb/spi_host_model.sv
// Host controller model that drives mode-0 serial frames into the flag bank.
`timescale 1ns/1ns
module spi_host_model (
   input  wire logic clk,
   input  wire logic miso,
   input  wire logic miso_oe,
   output logic      sclk,
   output logic      cs_n,
   output logic      mosi
);
   // Lines start deselected with the serial clock parked low.
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // frame length and hold.
   // One frame MSB first; nclk and extra let a test break the length or hold rules.
   task automatic xfer(input logic [15:0] tx, input int nclk, input int extra,
                       output logic [15:0] rx);
      int i;
      rx = 16'h0000;
      @(posedge clk);
      cs_n <= 1'b0;
      for (i = 0; i < nclk; i++) begin
         mosi <= tx[15-i];
         repeat (5) @(posedge clk);
         sclk <= 1'b1;
         rx = {rx[14:0], miso_oe ? miso : 1'bx};
         repeat (5) @(posedge clk);
         sclk <= 1'b0;
      end
      repeat (5 + extra) @(posedge clk);
      cs_n <= 1'b1;
      // A released data line must not keep its last level.
      mosi <= ~mosi;
      repeat (8) @(posedge clk);
   endtask
endmodule

// >>> tb/tb_event_flag_status_bank.sv
// Self-checking bench for the event flag bank and its serial port.
`timescale 1ns/1ns
module tb_event_flag_status_bank;
   import flag_bank_pkg::*;
   logic        clk = 1'b0;
   logic        arst_n, clk_en, sclk, cs_n, mosi, miso, miso_oe;
   logic [13:0] ev;
   logic [7:0]  mw, se, rs, ro;
   logic [31:0] exp_flags;
   logic [15:0] rx;
   int          mismatches = 0;
   int          comparisons = 0;
   int          i, k;
   logic [5:0]  addrs [4] = '{OFS_MCU_WARNING, OFS_SERIAL_ERROR,
                               OFS_RAIL_SHORT, OFS_RAIL_OVERVOLT};
   int          pos [14] = '{27, 22, 21, 20, 15, 14, 12, 9, 8, 7, 6, 4, 1, 0};
   logic [15:0] etx [4] = '{16'h3C00, 16'h3C01, 16'h0A01, 16'h3C01};
   int          enc [4] = '{16, 15, 16, 16};
   int          eext [4] = '{0, 0, 0, 250};

   // Clock at 100 MHz.
   always #5 clk = ~clk;

   event_flag_status_bank #(.SELECT_LIMIT_CYCLES(200)) i_event_flag_status_bank (
      .clk(clk), .arst_n(arst_n), .clk_en(clk_en), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
      .miso(miso), .miso_oe(miso_oe), .watchdog_missed_trigger(ev[0]),
      .output_ctrl_access_error(ev[1]), .device_ctrl_access_error(ev[2]),
      .lock_access_error(ev[3]), .ext_rail_two_short(ev[4]), .ext_rail_one_short(ev[5]),
      .stepup_short(ev[6]), .stepdown_two_short(ev[7]), .stepdown_one_short(ev[8]),
      .ext_rail_two_overvoltage(ev[9]), .ext_rail_one_overvoltage(ev[10]),
      .stepup_overvoltage(ev[11]), .stepdown_two_overvoltage(ev[12]),
      .stepdown_one_overvoltage(ev[13]), .mcu_warning_flags(mw),
      .serial_error_flags(se), .rail_short_flags(rs), .rail_overvoltage_flags(ro));

   spi_host_model i_spi_host_model (
      .clk(clk), .miso(miso), .miso_oe(miso_oe), .sclk(sclk), .cs_n(cs_n), .mosi(mosi));

   ////////////////////////////////////////////////////////////////////////////////
   // Frame word: write flag, address, data and odd parity over all sixteen bits.
   function automatic logic [15:0] mk(input logic w, input logic [5:0] a, input logic [7:0] d);
      logic [15:0] f;
      f = {w, a, d, 1'b0};
      f[0] = ~(^f[15:1]);
      return f;
   endfunction

   // Compares one value and reports a difference at once.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD t=%0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // Write-one-to-clear frame to one register.
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      i_spi_host_model.xfer(mk(1'b1, a, d), 16, 0, rx);
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Cuts a hang short.
   initial begin
      repeat (100000) @(posedge clk);
      mismatches++;
      finish_test();
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      arst_n = 1'b0;
      clk_en = 1'b1;
      ev = 14'h0000;
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      check({mw, se, rs, ro}, 32'h0000_0000, "reset values");
      $display("test reset done");
      // Each event sets exactly its own flag and the others stay.
      exp_flags = 32'h0000_0000;
      for (i = 0; i < 14; i++) begin
         @(posedge clk);
         ev <= 14'h0001 << i;
         exp_flags[pos[i]] = 1'b1;
         @(posedge clk);
         ev <= 14'h0000;
         @(posedge clk);
         check({mw, se}, exp_flags[31:16], "event warn");
         check(rs, exp_flags[15:8], "event short");
         check(ro, exp_flags[7:0], "event over");
      end
      $display("test events done");
      // Reads answer in the next frame with the address echo and flags.
      i_spi_host_model.xfer(mk(1'b0, addrs[0], 8'h00), 16, 0, rx);
      for (k = 1; k < 5; k++) begin
         i_spi_host_model.xfer(mk(1'b0, addrs[k%4], 8'h00), 16, 0, rx);
         check({16'h0000, rx}, {16'h0000, mk(1'b0, addrs[k-1], exp_flags[39-8*k -: 8])}, "read");
      end
      $display("test reads done");
      // Zero leaves a flag alone, one clears only that flag.
      wr(OFS_RAIL_SHORT, 8'h00);
      check({mw, se, rs, ro}, exp_flags, "write zero");
      wr(OFS_RAIL_SHORT, 8'h01);
      exp_flags[8] = 1'b0;
      check({mw, se, rs, ro}, exp_flags, "write one");
      // An event held through its clear keeps the flag set.
      @(posedge clk);
      ev <= 14'h0400;
      for (k = 0; k < 4; k++) begin
         wr(addrs[k], 8'hFF);
      end
      ev <= 14'h0000;
      check({mw, se, rs, ro}, 32'h0000_0040, "set over clear");
      wr(OFS_RAIL_OVERVOLT, 8'hFF);
      check({mw, se, rs, ro}, 32'h0000_0000, "all cleared");
      // Events are ignored while the clock enable is low.
      @(posedge clk);
      clk_en <= 1'b0;
      ev <= 14'h3FFF;
      repeat (3) @(posedge clk);
      ev <= 14'h0000;
      clk_en <= 1'b1;
      repeat (2) @(posedge clk);
      check({mw, se, rs, ro}, 32'h0000_0000, "frozen");
      $display("test clears done");
      // Parity, length, address and duration faults, each cleared afterwards.
      for (k = 0; k < 4; k++) begin
         i_spi_host_model.xfer(etx[k], enc[k], eext[k], rx);
         check(se, 8'h01 << k, "serial fault");
         wr(OFS_SERIAL_ERROR, 8'hFF);
         check({16'h0000, rx}, 32'h0000_0000, "answer after fault");
         check({24'h00_0000, se}, 32'h0000_0000, "fault cleared");
      end
      $display("test serial faults done");
      finish_test();
   end
endmodule
